//--- common/dapc_pkg.sv
// Shared constants for the dual audio port clocking block
package dapc_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// Sample rate ranges per speed
	localparam int unsigned SS_FS_MIN_HZ = 4_000;
	localparam int unsigned SS_FS_MAX_HZ = 54_000;
	localparam int unsigned DS_FS_MIN_HZ = 50_000;
	localparam int unsigned DS_FS_MAX_HZ = 108_000;
	localparam logic SPEED_SINGLE = 1'b0;
	localparam logic SPEED_DOUBLE = 1'b1;
	localparam logic FMT_LJ = 1'b0;
	localparam logic FMT_I2S = 1'b1;
	localparam logic MCLK_SEL_A = 1'b0;
	// Ratio field codes
	localparam logic [1:0] RATIO_X1 = 2'h0;
	localparam logic [1:0] RATIO_X1_5 = 2'h1;
	localparam logic [1:0] RATIO_X2 = 2'h2;
	localparam logic [1:0] RATIO_X3 = 2'h3;
	// Master ticks per bit clock in single speed, 4 bits per code
	// 256x:4, 384x:6, 512x:8, 768x:12; double speed halves them
	localparam logic [15:0] BIT_TICKS_SS = 16'hc864;
	localparam int unsigned TICK_FLD_W = 4;
	localparam logic [5:0] BITS_PER_FRAME_M1 = 6'h3f;
	localparam logic [5:0] HALF_FRAME = 6'h20;
	// Measured ratio at or above this, after halving, is single speed
	localparam logic [9:0] DET_SPLIT = 10'he0;
	localparam logic [9:0] DET_MAX = 10'h3ff;
	// Hardware mode pin codes {pin_a, pin_b}
	localparam logic [1:0] HW_MASTER_SS = 2'h0;
	localparam logic [1:0] HW_MASTER_DS = 2'h1;
	localparam logic [1:0] HW_RESERVED = 2'h2;
	localparam logic [1:0] HW_SLAVE_AUTO = 2'h3;
	// Converter indices
	localparam int unsigned CONV_REC = 0;
	localparam int unsigned CONV_PB_A = 1;
	localparam int unsigned CONV_PB_B = 2;
endpackage

//--- core/dapc_core.sv
// Clocking, routing and framing for two serial audio ports
`timescale 1ns/1ps
module dapc_core
#(
	parameter int unsigned SAMPLE_W = 24
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic master_clock_a_i,
	input wire logic master_clock_b_i,
	input wire logic hw_cfg_i,
	input wire logic hw_mode_pin_a_i,
	input wire logic hw_mode_pin_b_i,
	input wire logic mclk_halve_pin_i,
	input wire logic hw_format_pin_i,
	input wire logic port_a_master_i,
	input wire logic port_b_master_i,
	input wire logic port_a_speed_sel_i,
	input wire logic port_b_speed_sel_i,
	input wire logic [1:0] mclk_ratio_field_a_i,
	input wire logic [1:0] mclk_ratio_field_b_i,
	input wire logic port_a_mclk_sel_i,
	input wire logic port_b_mclk_sel_i,
	input wire logic auto_detect_i,
	input wire logic port_a_hiz_i,
	input wire logic port_b_hiz_i,
	input wire logic data_out_hiz_i,
	input wire logic [2:0] converter_port_sel_i,
	input wire logic [2:0] converter_mclk_sel_i,
	input wire logic [2:0] converter_fmt_i,
	input wire logic port_a_bit_clock_i,
	output logic port_a_bit_clock_o,
	output logic port_a_bit_clock_oe_o,
	input wire logic port_a_frame_clock_i,
	output logic port_a_frame_clock_o,
	output logic port_a_frame_clock_oe_o,
	input wire logic port_b_bit_clock_i,
	output logic port_b_bit_clock_o,
	output logic port_b_bit_clock_oe_o,
	input wire logic port_b_frame_clock_i,
	output logic port_b_frame_clock_o,
	output logic port_b_frame_clock_oe_o,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	input wire logic serial_data_in_a_i,
	input wire logic serial_data_in_b_i,
	input wire logic [SAMPLE_W-1:0] rec_left_i,
	input wire logic [SAMPLE_W-1:0] rec_right_i,
	output logic rec_take_o,
	output logic [SAMPLE_W-1:0] playback_conv_a_left_o,
	output logic [SAMPLE_W-1:0] playback_conv_a_right_o,
	output logic playback_conv_a_valid_o,
	output logic [SAMPLE_W-1:0] playback_conv_b_left_o,
	output logic [SAMPLE_W-1:0] playback_conv_b_right_o,
	output logic playback_conv_b_valid_o,
	output logic async_mode_o,
	output logic port_a_speed_o,
	output logic port_b_speed_o,
	output logic port_a_ratio_ok_o,
	output logic port_b_ratio_ok_o,
	output logic [2:0] converter_mclk_o,
	output logic [2:0] converter_speed_o
);
	localparam int unsigned CW = $clog2(SAMPLE_W + 2);
	localparam logic [CW-1:0] CNT_W = CW'(SAMPLE_W);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	typedef struct packed {
		logic [1:0] ma_s;
		logic [1:0] mb_s;
		logic ma_prev;
		logic mb_prev;
		logic [SAMPLE_W:0] rec_sh;
		logic sdo;
		logic [1:0][1:0] din_s;
		logic [1:0][CW-1:0] pb_cnt;
		logic [1:0][SAMPLE_W-1:0] pb_sh;
		logic [1:0][SAMPLE_W-1:0] pb_left;
		logic [1:0][SAMPLE_W-1:0] pb_right;
		logic [1:0] pb_valid;
		logic [2:0] cmclk;
		logic [2:0] cspeed;
		logic async_m;
	} dapc_st_t;

	dapc_st_t st_reg;
	dapc_st_t st_next;

	logic tick_a;
	logic tick_b;
	logic [1:0] hw_code;
	logic hw_master;
	logic hw_double;
	logic hw_auto;
	logic m_a;
	logic m_b;
	logic sp_a;
	logic sp_b;
	logic [1:0] rf_a;
	logic [1:0] rf_b;
	logic au_a;
	logic au_b;
	logic ms_a;
	logic ms_b;
	logic bclk_a;
	logic fclk_a;
	logic rise_a;
	logic fr_a;
	logic fe_a;
	logic bclk_b;
	logic fclk_b;
	logic rise_b;
	logic fr_b;
	logic fe_b;
	logic [2:0] fmt;
	logic [2:0] c_rise;
	logic [2:0] c_fe;
	logic [2:0] c_fr;
	logic left_ch;
	logic [SAMPLE_W:0] ld;
	logic [CW-1:0] k;
	logic capt;
	logic din;
	logic pb_left_prev;

	// Hardware pin decode; reserved code stays a silent slave
	always_comb
	begin
		hw_code = {hw_mode_pin_a_i, hw_mode_pin_b_i};
		hw_master = 1'b0;
		hw_double = dapc_pkg::SPEED_SINGLE;
		hw_auto = 1'b0;
		if (hw_code == dapc_pkg::HW_MASTER_SS)
		begin
			hw_master = 1'b1;
		end
		else if (hw_code == dapc_pkg::HW_MASTER_DS)
		begin
			hw_master = 1'b1;
			hw_double = dapc_pkg::SPEED_DOUBLE;
		end
		else if (hw_code == dapc_pkg::HW_SLAVE_AUTO)
		begin
			hw_auto = 1'b1;
		end
	end

	// Per-port settings, software or pins
	always_comb
	begin
		m_a = hw_cfg_i ? hw_master : port_a_master_i;
		m_b = hw_cfg_i ? hw_master : port_b_master_i;
		sp_a = hw_cfg_i ? hw_double : port_a_speed_sel_i;
		sp_b = hw_cfg_i ? hw_double : port_b_speed_sel_i;
		// Halve pin maps onto the x2 code of the ratio field
		rf_a = hw_cfg_i ? (mclk_halve_pin_i ? dapc_pkg::RATIO_X2 : dapc_pkg::RATIO_X1)
			: mclk_ratio_field_a_i;
		rf_b = hw_cfg_i ? (mclk_halve_pin_i ? dapc_pkg::RATIO_X2 : dapc_pkg::RATIO_X1)
			: mclk_ratio_field_b_i;
		au_a = hw_cfg_i ? hw_auto : auto_detect_i;
		au_b = hw_cfg_i ? hw_auto : auto_detect_i;
		ms_a = hw_cfg_i ? dapc_pkg::MCLK_SEL_A : port_a_mclk_sel_i;
		ms_b = hw_cfg_i ? dapc_pkg::MCLK_SEL_A : port_b_mclk_sel_i;
		tick_a = st_reg.ma_s[1] && !st_reg.ma_prev;
		tick_b = st_reg.mb_s[1] && !st_reg.mb_prev;
	end

	// Fast clock only samples the master clocks, good to about 45 MHz
	dapc_port_clk u_port_a
	(
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.mclk_tick_i(ms_a ? tick_b : tick_a),
		.master_i(m_a),
		.speed_sel_i(sp_a),
		.ratio_field_i(rf_a),
		.auto_i(au_a),
		.bclk_pin_i(port_a_bit_clock_i),
		.fclk_pin_i(port_a_frame_clock_i),
		.bclk_o(bclk_a),
		.fclk_o(fclk_a),
		.bit_rise_o(rise_a),
		.frame_o(fr_a),
		.frame_edge_o(fe_a),
		.speed_o(port_a_speed_o),
		.ratio_ok_o(port_a_ratio_ok_o)
	);

	dapc_port_clk u_port_b
	(
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.mclk_tick_i(ms_b ? tick_b : tick_a),
		.master_i(m_b),
		.speed_sel_i(sp_b),
		.ratio_field_i(rf_b),
		.auto_i(au_b),
		.bclk_pin_i(port_b_bit_clock_i),
		.fclk_pin_i(port_b_frame_clock_i),
		.bclk_o(bclk_b),
		.fclk_o(fclk_b),
		.bit_rise_o(rise_b),
		.frame_o(fr_b),
		.frame_edge_o(fe_b),
		.speed_o(port_b_speed_o),
		.ratio_ok_o(port_b_ratio_ok_o)
	);

	always_comb
	begin
		st_next = st_reg;
		st_next.ma_s = {st_reg.ma_s[0], master_clock_a_i};
		st_next.mb_s = {st_reg.mb_s[0], master_clock_b_i};
		st_next.ma_prev = st_reg.ma_s[1];
		st_next.mb_prev = st_reg.mb_s[1];
		st_next.async_m = !hw_cfg_i && (port_a_mclk_sel_i != port_b_mclk_sel_i);
		for (int c = 0; c < 3; c++)
		begin
			fmt[c] = hw_cfg_i ? hw_format_pin_i : converter_fmt_i[c];
			c_rise[c] = converter_port_sel_i[c] ? rise_b : rise_a;
			c_fe[c] = converter_port_sel_i[c] ? fe_b : fe_a;
			c_fr[c] = converter_port_sel_i[c] ? fr_b : fr_a;
			st_next.cmclk[c] = hw_cfg_i ? dapc_pkg::MCLK_SEL_A : converter_mclk_sel_i[c];
			st_next.cspeed[c] = converter_port_sel_i[c] ? port_b_speed_o : port_a_speed_o;
		end
		// Record side: word loaded at each channel change
		left_ch = (fmt[dapc_pkg::CONV_REC] == dapc_pkg::FMT_I2S)
			? c_fr[dapc_pkg::CONV_REC] : !c_fr[dapc_pkg::CONV_REC];
		ld = '0;
		rec_take_o = c_fe[dapc_pkg::CONV_REC];
		if (c_fe[dapc_pkg::CONV_REC])
		begin
			// One idle bit ahead of the word in inter-chip sound framing
			if (fmt[dapc_pkg::CONV_REC] == dapc_pkg::FMT_I2S)
			begin
				ld = {1'b0, left_ch ? rec_left_i : rec_right_i};
			end
			else
			begin
				ld = {left_ch ? rec_left_i : rec_right_i, 1'b0};
			end
			st_next.sdo = ld[SAMPLE_W];
			st_next.rec_sh = {ld[SAMPLE_W-1:0], 1'b0};
		end
		else if (c_rise[dapc_pkg::CONV_REC])
		begin
			st_next.sdo = st_reg.rec_sh[SAMPLE_W];
			st_next.rec_sh = {st_reg.rec_sh[SAMPLE_W-1:0], 1'b0};
		end
		// Playback side: two identical deserialisers
		st_next.din_s[0] = {st_reg.din_s[0][0], serial_data_in_a_i};
		st_next.din_s[1] = {st_reg.din_s[1][0], serial_data_in_b_i};
		st_next.pb_valid = '0;
		k = '0;
		capt = 1'b0;
		din = 1'b0;
		pb_left_prev = 1'b0;
		for (int p = 0; p < 2; p++)
		begin
			din = st_reg.din_s[p][1];
			if (c_rise[p + 1])
			begin
				k = st_reg.pb_cnt[p];
				if (c_fe[p + 1])
				begin
					// Finished word belongs to the channel just left
					pb_left_prev = (fmt[p + 1] == dapc_pkg::FMT_I2S) ? !c_fr[p + 1] : c_fr[p + 1];
					if (pb_left_prev)
					begin
						st_next.pb_left[p] = st_reg.pb_sh[p];
					end
					else
					begin
						st_next.pb_right[p] = st_reg.pb_sh[p];
						st_next.pb_valid[p] = 1'b1;
					end
					st_next.pb_sh[p] = '0;
					k = '0;
				end
				if (fmt[p + 1] == dapc_pkg::FMT_I2S)
				begin
					capt = (k >= CNT_ONE) && (k <= CNT_W);
				end
				else
				begin
					capt = (k < CNT_W);
				end
				if (capt)
				begin
					st_next.pb_sh[p] = c_fe[p + 1] ? SAMPLE_W'(din)
						: {st_reg.pb_sh[p][SAMPLE_W-2:0], din};
				end
				if (k <= CNT_W)
				begin
					st_next.pb_cnt[p] = k + CNT_ONE;
				end
				else
				begin
					st_next.pb_cnt[p] = k;
				end
			end
		end
		if (!ce_i)
		begin
			st_next = st_reg;
			rec_take_o = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Pin drivers; float lets another master own the wires
	assign port_a_bit_clock_o = bclk_a;
	assign port_a_frame_clock_o = fclk_a;
	assign port_a_bit_clock_oe_o = m_a && !port_a_hiz_i;
	assign port_a_frame_clock_oe_o = m_a && !port_a_hiz_i;
	assign port_b_bit_clock_o = bclk_b;
	assign port_b_frame_clock_o = fclk_b;
	assign port_b_bit_clock_oe_o = m_b && !port_b_hiz_i;
	assign port_b_frame_clock_oe_o = m_b && !port_b_hiz_i;
	assign serial_data_out_o = st_reg.sdo;
	assign serial_data_out_oe_o = !data_out_hiz_i;
	assign playback_conv_a_left_o = st_reg.pb_left[0];
	assign playback_conv_a_right_o = st_reg.pb_right[0];
	assign playback_conv_a_valid_o = st_reg.pb_valid[0];
	assign playback_conv_b_left_o = st_reg.pb_left[1];
	assign playback_conv_b_right_o = st_reg.pb_right[1];
	assign playback_conv_b_valid_o = st_reg.pb_valid[1];
	assign async_mode_o = st_reg.async_m;
	assign converter_mclk_o = st_reg.cmclk;
	assign converter_speed_o = st_reg.cspeed;
endmodule

//--- core/dapc_port_clk.sv
// Bit and frame clock engine for one serial audio port
`timescale 1ns/1ps
module dapc_port_clk
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic mclk_tick_i,
	input wire logic master_i,
	input wire logic speed_sel_i,
	input wire logic [1:0] ratio_field_i,
	input wire logic auto_i,
	input wire logic bclk_pin_i,
	input wire logic fclk_pin_i,
	output logic bclk_o,
	output logic fclk_o,
	output logic bit_rise_o,
	output logic frame_o,
	output logic frame_edge_o,
	output logic speed_o,
	output logic ratio_ok_o
);
	typedef struct packed {
		logic [1:0] bsync;
		logic [1:0] fsync;
		logic bprev;
		logic fprev;
		logic fsmp;
		logic [3:0] tick_cnt;
		logic [5:0] bit_cnt;
		logic gbclk;
		logic gfclk;
		logic [9:0] mcnt;
		logic det_speed;
		logic det_ok;
	} dapc_pc_t;

	dapc_pc_t st_reg;
	dapc_pc_t st_next;
	logic [3:0] ticks;
	logic [3:0] tc;
	logic [5:0] bc;
	logic bseen;
	logic fseen;
	logic speed;
	logic [9:0] eff;

	always_comb
	begin
		st_next = st_reg;
		// Slave clocks pass two flops before use
		st_next.bsync = {st_reg.bsync[0], bclk_pin_i};
		st_next.fsync = {st_reg.fsync[0], fclk_pin_i};
		speed = (auto_i && !master_i) ? st_reg.det_speed : speed_sel_i;
		ticks = BIT_TICKS_SS_at(ratio_field_i);
		if (speed == dapc_pkg::SPEED_DOUBLE)
		begin
			ticks = ticks >> 1;
		end
		tc = st_reg.tick_cnt;
		bc = st_reg.bit_cnt;
		if (!master_i)
		begin
			tc = '0;
			bc = '0;
		end
		else if (mclk_tick_i)
		begin
			// Wraps on the next master tick if a lower ratio leaves the count past its end
			if (tc >= ticks - 4'h1)
			begin
				tc = '0;
				bc = bc + 6'h1;
			end
			else
			begin
				tc = tc + 4'h1;
			end
		end
		st_next.tick_cnt = tc;
		st_next.bit_cnt = bc;
		st_next.gbclk = master_i && (tc >= (ticks >> 1));
		st_next.gfclk = master_i && (bc >= dapc_pkg::HALF_FRAME);
		bseen = master_i ? st_reg.gbclk : st_reg.bsync[1];
		fseen = master_i ? st_reg.gfclk : st_reg.fsync[1];
		st_next.bprev = bseen;
		st_next.fprev = fseen;
		bit_rise_o = bseen && !st_reg.bprev;
		frame_edge_o = bit_rise_o && (fseen != st_reg.fsmp);
		if (bit_rise_o)
		begin
			st_next.fsmp = fseen;
		end
		// Ratio measure: master ticks per frame, halved per field
		eff = ratio_field_i[1] ? (st_reg.mcnt >> 1) : st_reg.mcnt;
		if (fseen && !st_reg.fprev)
		begin
			st_next.det_speed = (eff < dapc_pkg::DET_SPLIT);
			st_next.det_ok = (st_reg.mcnt != dapc_pkg::DET_MAX) && (st_reg.mcnt != '0);
			st_next.mcnt = {9'h000, mclk_tick_i};
		end
		else if (mclk_tick_i && st_reg.mcnt != dapc_pkg::DET_MAX)
		begin
			st_next.mcnt = st_reg.mcnt + 10'h001;
		end
		if (!ce_i)
		begin
			st_next = st_reg;
			bit_rise_o = 1'b0;
			frame_edge_o = 1'b0;
		end
	end

	function automatic logic [3:0] BIT_TICKS_SS_at(input logic [1:0] f);
		BIT_TICKS_SS_at = dapc_pkg::BIT_TICKS_SS[{f, 2'b00} +: dapc_pkg::TICK_FLD_W];
	endfunction

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign bclk_o = st_reg.gbclk;
	assign fclk_o = st_reg.gfclk;
	assign frame_o = st_reg.fsmp;
	assign speed_o = (auto_i && !master_i) ? st_reg.det_speed : speed_sel_i;
	assign ratio_ok_o = master_i || !auto_i || st_reg.det_ok;
endmodule

//--- dv/dapc_core_asserts.sv
// Port-level checks on the dual audio port clocking core
`timescale 1ns/1ps
module dapc_core_asserts
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic hw_cfg_i,
	input wire logic hw_mode_pin_a_i,
	input wire logic hw_mode_pin_b_i,
	input wire logic port_a_master_i,
	input wire logic port_b_master_i,
	input wire logic port_a_speed_sel_i,
	input wire logic port_a_mclk_sel_i,
	input wire logic port_b_mclk_sel_i,
	input wire logic port_a_hiz_i,
	input wire logic port_b_hiz_i,
	input wire logic data_out_hiz_i,
	input wire logic [2:0] converter_port_sel_i,
	input wire logic port_a_bit_clock_oe_o,
	input wire logic port_b_frame_clock_oe_o,
	input wire logic serial_data_out_oe_o,
	input wire logic async_mode_o,
	input wire logic port_a_speed_o,
	input wire logic port_b_speed_o,
	input wire logic [2:0] converter_mclk_o,
	input wire logic [2:0] converter_speed_o
);
	logic ma;
	logic mb;
	logic async_want;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// Reserved pin code lands on the slave side, so neither port drives its clocks
	assign ma = hw_cfg_i ? !hw_mode_pin_a_i : port_a_master_i;
	assign mb = hw_cfg_i ? !hw_mode_pin_a_i : port_b_master_i;
	assign async_want = !hw_cfg_i && (port_a_mclk_sel_i != port_b_mclk_sel_i);
	sequence hw_double;
		hw_cfg_i && !hw_mode_pin_a_i && hw_mode_pin_b_i;
	endsequence
	sequence sw_master_a;
		!hw_cfg_i && port_a_master_i && $stable(port_a_speed_sel_i);
	endsequence
	sequence conv_quiet;
		ce_i && $stable(converter_port_sel_i) && $stable(port_a_speed_o) && $stable(port_b_speed_o);
	endsequence
	AST_OE_A: assert property (port_a_bit_clock_oe_o == (ma && !port_a_hiz_i))
		else $error("port a clock enable wrong");
	AST_OE_B: assert property (port_b_frame_clock_oe_o == (mb && !port_b_hiz_i))
		else $error("port b clock enable wrong");
	AST_SDO_OE: assert property (serial_data_out_oe_o != data_out_hiz_i)
		else $error("data out enable wrong");
	AST_ASYNC: assert property (ce_i |=> async_mode_o == $past(async_want))
		else $error("async mode flag wrong");
	AST_HW_MCLK: assert property (hw_cfg_i && ce_i |=> converter_mclk_o == 3'h0)
		else $error("converter clock select set in hardware mode");
	AST_HW_DS: assert property (hw_double [*3] |-> port_a_speed_o && port_b_speed_o)
		else $error("hardware double speed not applied");
	AST_SW_SPEED: assert property (sw_master_a [*3] |-> port_a_speed_o == port_a_speed_sel_i)
		else $error("port a speed does not follow its setting");
	AST_CONV_SPEED: assert property (conv_quiet [*3] |->
		converter_speed_o[2] == (converter_port_sel_i[2] ? port_b_speed_o : port_a_speed_o))
		else $error("converter speed not that of its port");
endmodule

//--- dv/dapc_far_end.sv
// Far-end audio processor: master clocks, slave port clocks, playback data
`timescale 1ns/1ps
module dapc_far_end
(
	input wire logic clk_i,
	input wire logic drive_i,
	input wire logic i2s_i,
	input wire logic [23:0] left_i,
	input wire logic [23:0] right_i,
	output logic mclk_a_o,
	output logic mclk_b_o,
	output logic bclk_o,
	output logic fclk_o,
	output logic sdata_o,
	input wire logic rx_bclk_i,
	input wire logic rx_fclk_i,
	input wire logic rx_data_i,
	output logic [23:0] rx_left_o,
	output logic [23:0] rx_right_o
);
	logic [10:0] cnt = 11'h000;
	logic [31:0] rx_sh = 32'h0;
	logic rx_fprev = 1'b0;
	// Record receiver: samples on the bit clock rising edge, MSB first
	always @(posedge rx_bclk_i)
	begin
		rx_sh = {rx_sh[30:0], rx_data_i};
		if (rx_fclk_i != rx_fprev)
		begin
			if (rx_fprev ^ i2s_i)
				rx_left_o <= i2s_i ? rx_sh[30:7] : rx_sh[31:8];
			else
				rx_right_o <= i2s_i ? rx_sh[30:7] : rx_sh[31:8];
		end
		rx_fprev = rx_fclk_i;
	end
	logic [4:0] slot;
	logic [23:0] word;
	always @(posedge clk_i)
		cnt <= cnt + 11'h001;
	// Clock b at half the rate of a, so async clocking shows in periods
	assign mclk_a_o = cnt[1];
	assign mclk_b_o = cnt[2];
	// Four master b periods a bit, 64 bits a frame: 256x; still when idle
	assign bclk_o = drive_i && cnt[4];
	assign fclk_o = drive_i && cnt[10];
	assign slot = cnt[9:5];
	assign word = (cnt[10] ^ i2s_i) ? left_i : right_i;
	// Data moves on the falling bit edge; unused slots toggle every bit
	always_comb
	begin
		sdata_o = cnt[5];
		if (drive_i && !i2s_i && slot < 5'd24)
			sdata_o = word[5'd23 - slot];
		if (drive_i && i2s_i && slot != 5'd0 && slot < 5'd25)
			sdata_o = word[5'd24 - slot];
	end
endmodule

//--- dv/tb.sv
// Self-checking bench for the dual audio port clocking core
`timescale 1ns/1ps
module tb;
	localparam logic [23:0] LW = 24'hc3a501;
	localparam logic [23:0] RW = 24'h5e0f82;
	localparam int TK [4] = '{4, 6, 8, 12};
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i, hw_cfg_i, hw_mode_pin_a_i, hw_mode_pin_b_i, mclk_halve_pin_i, auto_detect_i;
	logic port_a_master_i, port_b_master_i, port_a_speed_sel_i, port_b_speed_sel_i;
	logic [1:0] mclk_ratio_field_a_i, mclk_ratio_field_b_i;
	logic port_a_mclk_sel_i, port_b_mclk_sel_i, port_a_hiz_i, port_b_hiz_i, data_out_hiz_i;
	logic [2:0] converter_port_sel_i, converter_mclk_sel_i, converter_fmt_i, converter_mclk_o;
	logic master_clock_a_i, master_clock_b_i, far_drive, far_i2s, far_bclk, far_fclk, far_data;
	logic port_b_bit_clock_i, port_b_frame_clock_i, port_a_bit_clock_o, port_b_bit_clock_o;
	logic port_a_bit_clock_oe_o, port_b_frame_clock_oe_o, serial_data_out_oe_o, async_mode_o;
	logic port_b_bit_clock_oe_o, port_b_frame_clock_o, port_a_frame_clock_o, port_b_speed_o;
	logic port_b_ratio_ok_o, playback_conv_b_valid_o;
	logic [23:0] playback_conv_a_left_o, playback_conv_a_right_o;
	logic [23:0] playback_conv_b_left_o, playback_conv_b_right_o;
	logic [2:0] mon;
	logic hw_format_pin_i, rec_data;
	logic [23:0] rx_left, rx_right;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	assign port_b_bit_clock_i = port_b_bit_clock_oe_o ? port_b_bit_clock_o : far_bclk;
	assign port_b_frame_clock_i = port_b_frame_clock_oe_o ? port_b_frame_clock_o : far_fclk;
	assign mon = {port_a_frame_clock_o, port_b_bit_clock_o, port_a_bit_clock_o};
	always #5 clk_i = ~clk_i;
	dapc_far_end far
	(
		.clk_i, .drive_i(far_drive), .i2s_i(far_i2s), .left_i(LW), .right_i(RW),
		.mclk_a_o(master_clock_a_i), .mclk_b_o(master_clock_b_i), .bclk_o(far_bclk),
		.fclk_o(far_fclk), .sdata_o(far_data), .rx_bclk_i(port_a_bit_clock_o),
		.rx_fclk_i(port_a_frame_clock_o), .rx_data_i(rec_data), .rx_left_o(rx_left),
		.rx_right_o(rx_right)
	);
	dapc_core #(.SAMPLE_W(24)) dut
	(
		.clk_i, .reset_i, .ce_i, .master_clock_a_i, .master_clock_b_i, .hw_cfg_i,
		.hw_mode_pin_a_i, .hw_mode_pin_b_i, .mclk_halve_pin_i, .hw_format_pin_i,
		.port_a_master_i, .port_b_master_i, .port_a_speed_sel_i, .port_b_speed_sel_i,
		.mclk_ratio_field_a_i, .mclk_ratio_field_b_i, .port_a_mclk_sel_i, .port_b_mclk_sel_i,
		.auto_detect_i, .port_a_hiz_i, .port_b_hiz_i, .data_out_hiz_i, .converter_port_sel_i,
		.converter_mclk_sel_i, .converter_fmt_i, .port_a_bit_clock_i(1'b0), .port_a_bit_clock_o,
		.port_a_bit_clock_oe_o, .port_a_frame_clock_i(1'b0), .port_a_frame_clock_o,
		.port_a_frame_clock_oe_o(), .port_b_bit_clock_i, .port_b_bit_clock_o,
		.port_b_bit_clock_oe_o, .port_b_frame_clock_i, .port_b_frame_clock_o,
		.port_b_frame_clock_oe_o, .serial_data_out_o(rec_data), .serial_data_out_oe_o,
		.serial_data_in_a_i(far_data), .serial_data_in_b_i(far_data), .rec_left_i(LW),
		.rec_right_i(RW), .rec_take_o(), .playback_conv_a_left_o, .playback_conv_a_right_o,
		.playback_conv_a_valid_o(), .playback_conv_b_left_o, .playback_conv_b_right_o,
		.playback_conv_b_valid_o, .async_mode_o, .port_a_speed_o(), .port_b_speed_o,
		.port_a_ratio_ok_o(), .port_b_ratio_ok_o, .converter_mclk_o, .converter_speed_o()
	);
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Cycles between two rising edges of a watched clock
	task automatic period(input int w, output logic [23:0] n);
		logic prev;
		int k;
		n = 24'h0;
		prev = 1'b1;
		k = 0;
		while (k < 2 && n < 24'h1000)
		begin
			@(posedge clk_i);
			if (k == 1)
				n++;
			if (mon[w] && !prev)
				k++;
			prev = mon[w];
		end
	endtask
	// First period after a change may be partial, so judge the second
	task automatic chkper(input int w, input logic [23:0] exp);
		logic [23:0] n;
		period(w, n);
		period(w, n);
		check(n, exp);
	endtask
	task automatic wait_valid();
		int g;
		g = 0;
		do
		begin
			@(posedge clk_i);
			g++;
		end
		while (!playback_conv_b_valid_o && g < 4000);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			$display("ERROR t=%0t run did not finish", $time);
			print_verdict();
		end
	end
	initial
	begin
		{ce_i, hw_cfg_i, hw_mode_pin_a_i, hw_mode_pin_b_i, mclk_halve_pin_i} = 5'h10;
		{port_a_master_i, port_b_master_i, port_a_speed_sel_i, port_b_speed_sel_i} = 4'hc;
		{mclk_ratio_field_a_i, mclk_ratio_field_b_i, far_drive, far_i2s} = 6'h00;
		{port_a_mclk_sel_i, port_b_mclk_sel_i, auto_detect_i} = 3'h0;
		{port_a_hiz_i, port_b_hiz_i, data_out_hiz_i} = 3'h0;
		{converter_port_sel_i, converter_mclk_sel_i, converter_fmt_i, hw_format_pin_i} = 10'h000;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 4; c++)
			begin
				port_a_speed_sel_i <= s[0];
				mclk_ratio_field_a_i <= c[1:0];
				chkper(0, 24'((TK[c] >> s) * 4));
			end
		port_a_speed_sel_i <= 1'b0;
		mclk_ratio_field_a_i <= 2'h0;
		chkper(2, 24'd1024);
		port_b_mclk_sel_i <= 1'b1;
		chkper(1, 24'd32);
		check(async_mode_o, 1'b1);
		port_b_mclk_sel_i <= 1'b0;
		port_b_speed_sel_i <= 1'b1;
		chkper(1, 24'd8);
		chkper(0, 24'd16);
		check(async_mode_o, 1'b0);
		$display("done: clock ratios and clock modes");
		for (int h = 0; h < 8; h++)
		begin
			{port_a_hiz_i, port_b_hiz_i, data_out_hiz_i} <= h[2:0];
			@(negedge clk_i);
			check(port_a_bit_clock_oe_o, !h[2]);
			check(port_b_frame_clock_oe_o, !h[1]);
			check(serial_data_out_oe_o, !h[0]);
			@(posedge clk_i);
		end
		{port_a_hiz_i, port_b_hiz_i, data_out_hiz_i} <= 3'h0;
		$display("done: output floating");
		{hw_cfg_i, port_b_mclk_sel_i, converter_mclk_sel_i} <= 5'h1f;
		for (int i = 0; i < 4; i++)
		begin
			{hw_mode_pin_b_i, mclk_halve_pin_i} <= i[1:0];
			chkper(0, 24'd16 << i[0] >> i[1]);
		end
		check(async_mode_o, 1'b0);
		check(converter_mclk_o, 3'h0);
		for (int i = 2; i < 4; i++)
		begin
			{hw_mode_pin_a_i, hw_mode_pin_b_i} <= i[1:0];
			@(negedge clk_i);
			check(port_a_bit_clock_oe_o, 1'b0);
			@(posedge clk_i);
		end
		hw_cfg_i <= 1'b0;
		$display("done: hardware pins");
		{port_b_master_i, auto_detect_i, far_drive} <= 3'h3;
		converter_port_sel_i <= 3'h6;
		converter_mclk_sel_i <= 3'h6;
		// Left justified, inter-chip sound, then pins with format pin high
		for (int f = 0; f < 3; f++)
		begin
			converter_fmt_i <= {3{f[0]}};
			far_i2s <= (f != 0);
			{hw_cfg_i, hw_format_pin_i} <= {2{f[1]}};
			repeat (3) wait_valid();
			check(playback_conv_b_left_o, LW);
			check(playback_conv_b_right_o, RW);
			check(playback_conv_a_left_o, LW);
			check(playback_conv_a_right_o, RW);
			if (f < 2)
			begin
				check(rx_left, LW);
				check(rx_right, RW);
			end
		end
		check(port_b_speed_o, dapc_pkg::SPEED_SINGLE);
		check(port_b_ratio_ok_o, 1'b1);
		$display("done: slave playback and speed detection");
		print_verdict();
	end
endmodule
bind dapc_core dapc_core_asserts chk
(
	.clk_i, .reset_i, .ce_i, .hw_cfg_i, .hw_mode_pin_a_i, .hw_mode_pin_b_i, .port_a_master_i,
	.port_b_master_i, .port_a_speed_sel_i, .port_a_mclk_sel_i, .port_b_mclk_sel_i, .port_a_hiz_i,
	.port_b_hiz_i, .data_out_hiz_i, .converter_port_sel_i, .port_a_bit_clock_oe_o,
	.port_b_frame_clock_oe_o, .serial_data_out_oe_o, .async_mode_o, .port_a_speed_o,
	.port_b_speed_o, .converter_mclk_o, .converter_speed_o
);
